// ===== bench/channel_status_paging_checker.sv
`timescale 1ns/1ns
module channel_status_paging_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link words
	input wire logic [15:0] control_output_channel_b,
	input wire logic [15:0] control_output_channel_a,
	input wire logic [15:0] status_input_channel_a,
	input wire logic [15:0] status_input_channel_b
);
	logic [15:0] cb;
	logic [15:0] sa;
	logic [15:0] sb;
	logic isc;
	logic isd;
	logic is6;
	assign cb = control_output_channel_b;
	assign sa = status_input_channel_a;
	assign sb = status_input_channel_b;
	assign isc = cb[15:12] == chan_status_pkg::CODE_CH0;
	assign isd = cb[15:12] == chan_status_pkg::CODE_CH1;
	assign is6 = cb[15:12] == chan_status_pkg::CODE_SCANNER;
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// *****
	// assertions
	// *****
	AST_RESET_ZERO: assert property (
		$rose(presetn) |-> sa == 16'h0000 && sb == 16'h0000)
		else $error("status words not clear after reset");
	AST_A_IDLE: assert property (
		sa != 16'h0000 |-> $past(isc || isd))
		else $error("channel a word without a connect code");
	AST_A_DISC: assert property (
		(!isc && !isd) [*2] |-> sa == 16'h0000)
		else $error("channel a word while disconnected");
	AST_B_IDLE: assert property (
		!isc && !isd && !is6 |=> sb == 16'h0000)
		else $error("channel b word without a valid code");
	AST_SCAN_SPARE: assert property (
		is6 |=> (sb & 16'hFC3C) == 16'h0000)
		else $error("scanner word has bits outside its fields");
	AST_SLOT0_LOAD: assert property (
		$fell(cb[1]) && isc ##[2:4] is6 |=> !sb[0])
		else $error("slot free 0 still set after page load");
	AST_SLOT1_LOAD: assert property (
		$fell(cb[1]) && isd ##[2:4] is6 |=> !sb[1])
		else $error("slot free 1 still set after page load");
	AST_RESP_CLEAR: assert property (
		isc && !$past(isc) ##[2:4] is6 |=> sb[7:6] == 2'b00)
		else $error("response 0 flags kept over a new connect");
endmodule : channel_status_paging_checker

// ===== bench/channel_status_paging_tb_top.sv
`timescale 1ns/1ns
module channel_status_paging_tb_top;
	localparam logic [11:0] CTL_ADR = chan_status_pkg::OFF_CTL;
	localparam logic [11:0] DT = chan_status_pkg::OFF_DATA;
	localparam logic [11:0] ST_A = chan_status_pkg::OFF_STAT_A;
	localparam logic [11:0] ST_B = chan_status_pkg::OFF_STAT_B;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] par = 2'h0, eor = 2'h0, refuse = 2'h0, reply = 2'h0;
	logic [1:0] intr = 2'h0, pcross = 2'h0, tahit = 2'h0;
	logic [1:0][11:0] cstat = '0;
	logic [1:0][10:0] caddr = '0;
	logic [1:0][3:0] bcnt = '0;
	logic cmd_valid, cmd_chan, lc, err;
	logic [6:0] cmd_kind, lk;
	logic [15:0] cmd_data, ld;
	logic [31:0] q;
	logic [3:0] oh;
	int ord [4] = '{0, 1, 3, 2};
	int n_fail = 0;
	int checks = 0;
	chan_link_if link (.pclk(pclk), .presetn(presetn));
	chan_status_host chan_status_host_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.host));
	chan_status_dev #(.REJECT_CYCLES(8)) chan_status_dev_inst (
		.link(link.dev), .ctrl_parity_err(par), .ctrl_eor(eor),
		.ctrl_refuse(refuse), .ctrl_reply(reply), .ctrl_interrupt(intr),
		.ctrl_status(cstat), .page_cross(pcross), .write_ta_hit(tahit),
		.cur_word_addr(caddr), .last_byte_count(bcnt),
		.cmd_valid(cmd_valid), .cmd_chan(cmd_chan), .cmd_kind(cmd_kind),
		.cmd_data(cmd_data));
	channel_status_paging_checker channel_status_paging_checker_inst (
		.pclk(pclk), .presetn(presetn),
		.control_output_channel_b(link.control_output_channel_b),
		.control_output_channel_a(link.control_output_channel_a),
		.status_input_channel_a(link.status_input_channel_a),
		.status_input_channel_b(link.status_input_channel_b));
	initial begin
		forever #20 pclk = ~pclk;
	end
	// cmd_valid stands one cycle, so keep the last order seen
	always @(posedge pclk) begin
		if (cmd_valid === 1'b1) begin
			lk <= cmd_kind;
			lc <= cmd_chan;
			ld <= cmd_data;
		end
	end
	// *****
	// tasks
	// *****
	function automatic logic [11:0] rev(input logic [11:0] v);
		for (int i = 0; i < 12; i++) begin
			rev[i] = v[11 - i];
		end
	endfunction : rev
	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge, so the next call never re-raises psel in this step
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0000, d});
	endtask : wr
	task automatic ctl(input logic [15:0] d);
		wr(CTL_ADR, d);
	endtask : ctl
	// set then clear, as the strobes act on the falling bit
	task automatic stb(input logic [3:0] c, input logic [6:0] b);
		ctl({c, 5'h00, b});
		ctl({c, 12'h000});
	endtask : stb
	// idle first: status lags the control word by up to three edges
	task automatic rd(input logic [11:0] a, input logic [31:0] m, e,
		input string nm);
		repeat (4) @(posedge pclk);
		apb(1'b0, a, 32'h00000000);
		chk(nm, q & m, e);
	endtask : rd
	// watchdog: the sequence needs well under 2000 cycles
	initial begin
		#200000;
		n_fail++;
		results();
	end
	// *****
	// tests
	// *****
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(CTL_ADR, ALL, 32'h0, "ctl_reset");
		rd(ST_A, ALL, 32'h0, "stat_a_reset");
		rd(ST_B, ALL, 32'h0, "stat_b_reset");
		rd(12'h010, ALL, 32'h0, "unmapped");
		chk("slverr", err, 32'h1);
		for (int ch = 0; ch < 2; ch++) begin
			cstat[ch] <= ch ? 12'h3C1 : 12'hA5C;
			ctl(ch ? 16'hD000 : 16'hC000);
			for (int i = 0; i < 4; i++) begin
				oh = 4'h1 << ord[i];
				{reply[ch], refuse[ch], eor[ch], par[ch]} <= oh;
				rd(ST_B, ALL, {rev(cstat[ch]), oh}, "ctrl");
			end
			{reply[ch], refuse[ch], eor[ch], par[ch]} <= 4'h0;
		end
		stb(4'hC, 7'h08);
		rd(ST_B, 32'h4, 32'h0, "reject_clear");
		wr(DT, 16'h1234);
		stb(4'hC, 7'h10);
		repeat (12) @(posedge pclk);
		chk("cmd_func", {lc, lk, ld}, {1'b0, 7'h10, 16'h1234});
		rd(ST_B, 32'h4, 32'h4, "reject_timeout");
		stb(4'hC, 7'h10);
		repeat (2) @(posedge pclk);
		reply[0] <= 1'b1;
		repeat (12) @(posedge pclk);
		rd(ST_B, 32'hC, 32'h8, "reject_replied");
		reply[0] <= 1'b0;
		caddr[0] <= 11'h5A3;
		bcnt[0] <= 4'h9;
		rd(ST_A, 32'h1E00, 32'h1200, "byte_count");
		stb(4'hC, 7'h40);
		rd(ST_A, 32'hFFE0, 32'hB460, "cur_addr");
		stb(4'hC, 7'h20);
		rd(ST_A, 32'h1E00, 32'h1200, "table_dummy");
		stb(4'hC, 7'h40);
		ctl(16'h6000);
		ctl(16'hC000);
		rd(ST_A, 32'h1E00, 32'h1200, "reconnect");
		ctl(16'hD000);
		pcross <= 2'h3;
		tahit <= 2'h1;
		intr <= 2'h2;
		@(posedge pclk);
		{pcross, tahit, intr} <= 6'h00;
		ctl(16'h6000);
		rd(ST_B, ALL, 32'h0183, "scan_set");
		ctl(16'hC000);
		ctl(16'h6000);
		rd(ST_B, ALL, 32'h0103, "resp0_clear");
		stb(4'hC, 7'h02);
		ctl(16'h6000);
		rd(ST_B, ALL, 32'h0102, "slot0_load");
		stb(4'hD, 7'h02);
		ctl(16'h6000);
		rd(ST_B, ALL, 32'h0000, "slot1_load");
		chk("cmd_page", {lc, lk}, {1'b1, 7'h02});
		results();
	end
endmodule : channel_status_paging_tb_top

// ===== verilog/chan_link_if.sv
`timescale 1ns/1ns
interface chan_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic [15:0] control_output_channel_b;
	logic [15:0] control_output_channel_a;
	logic [15:0] status_input_channel_a;
	logic [15:0] status_input_channel_b;
	modport dev (
		input pclk,
		input presetn,
		input control_output_channel_b,
		input control_output_channel_a,
		output status_input_channel_a,
		output status_input_channel_b
	);
	modport host (
		input pclk,
		input presetn,
		output control_output_channel_b,
		output control_output_channel_a,
		input status_input_channel_a,
		input status_input_channel_b
	);
endinterface : chan_link_if

// ===== verilog/chan_status_dev.sv
`timescale 1ns/1ns
module chan_status_dev #(
	parameter int REJECT_CYCLES = chan_status_pkg::REJECT_CYCLES
) (
	// link to the station control processor
	chan_link_if.dev link,
	// peripheral controller side, one entry per channel
	input wire logic [1:0] ctrl_parity_err,
	input wire logic [1:0] ctrl_eor,
	input wire logic [1:0] ctrl_refuse,
	input wire logic [1:0] ctrl_reply,
	input wire logic [1:0] ctrl_interrupt,
	input wire logic [1:0][11:0] ctrl_status,
	// transfer engine side, one entry per channel
	input wire logic [1:0] page_cross,
	input wire logic [1:0] write_ta_hit,
	input wire logic [1:0][10:0] cur_word_addr,
	input wire logic [1:0][3:0] last_byte_count,
	// orders forwarded to the transfer engine
	output logic cmd_valid,
	output logic cmd_chan,
	output logic [6:0] cmd_kind,
	output logic [15:0] cmd_data
);
	typedef struct packed {
		logic [15:0] ctl_prev;
		logic [1:0] cur_sel;
		logic [1:0] resp;
		logic [1:0] slot_free;
		logic [1:0] cmp;
		logic [1:0] tmo_run;
		logic [1:0] tmo_rej;
		logic [1:0][11:0] tmo_cnt;
		logic [15:0] stat_a;
		logic [15:0] stat_b;
		logic cmd_valid;
		logic cmd_chan;
		logic [6:0] cmd_kind;
		logic [15:0] cmd_data;
	} dev_state_t;

	dev_state_t state_reg;
	dev_state_t state_next;

	function automatic logic [3:0] code_of(input logic [15:0] w);
		code_of = w[chan_status_pkg::CTL_CODE_LSB +: 4];
	endfunction : code_of

	function automatic logic is_chan_code(input logic [3:0] c);
		is_chan_code = (c == chan_status_pkg::CODE_CH0) ||
			(c == chan_status_pkg::CODE_CH1);
	endfunction : is_chan_code

	logic [15:0] ctl;
	logic [3:0] code;
	logic connected;
	logic ch;
	logic new_connect;
	logic [6:0] fell;
	logic [6:0] rose;

	// ************************************************
	// control word decode
	// ************************************************
	always_comb begin
		ctl = link.control_output_channel_b;
		code = code_of(ctl);
		// paths exist only while the code stays on the channel
		connected = is_chan_code(code);
		ch = code[0];
		new_connect = connected && (code_of(state_reg.ctl_prev) != code);
		// strobes act on set-then-clear, so the falling edge loads
		fell = state_reg.ctl_prev[6:0] & ~ctl[6:0];
		rose = ~state_reg.ctl_prev[6:0] & ctl[6:0];
	end

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		logic [15:0] wa;
		logic [15:0] wb;
		logic [1:0] clr;
		wa = chan_status_pkg::STATUS_RESET;
		wb = chan_status_pkg::STATUS_RESET;
		clr = 2'b00;
		state_next = state_reg;
		state_next.ctl_prev = ctl;
		state_next.cmd_valid = 1'b0;

		if (connected && ctl[chan_status_pkg::CTL_PROG_CLEAR]) begin
			clr[ch] = 1'b1;
		end

		// status word selection on channel a
		if (new_connect) begin
			state_next.cur_sel[ch] = 1'b0;
		end else if (connected) begin
			if (rose[chan_status_pkg::CTL_CUR_ADDR]) begin
				state_next.cur_sel[ch] = 1'b1;
			end else if (fell[chan_status_pkg::CTL_TABLE_ADDR]) begin
				// dummy table address load drops back to default
				state_next.cur_sel[ch] = 1'b0;
			end
			// no clear on bit 6 falling: set-then-clear must keep it
		end

		// forwarded orders: one pulse per control word with falling strobe bits, kind holds them all
		if (connected && (fell != 7'h00)) begin
			state_next.cmd_valid = 1'b1;
			state_next.cmd_chan = ch;
			state_next.cmd_kind = fell;
			state_next.cmd_data = link.control_output_channel_a;
		end

		for (int i = 0; i < 2; i++) begin
			logic own;
			logic page_load;
			logic func_sent;
			own = connected && (ch == 1'(i));
			page_load = own && fell[chan_status_pkg::CTL_TERM_ADDR];
			func_sent = own && fell[chan_status_pkg::CTL_CHAN_FUNC];
			// sticky flags: the hardware set wins over any clear
			if (ctrl_eor[i] || ctrl_interrupt[i]) begin
				state_next.resp[i] = 1'b1;
			end else if ((own && new_connect) || clr[i]) begin
				state_next.resp[i] = 1'b0;
			end
			if (page_cross[i]) begin
				state_next.slot_free[i] = 1'b1;
			end else if (page_load || clr[i]) begin
				state_next.slot_free[i] = 1'b0;
			end
			if (write_ta_hit[i]) begin
				state_next.cmp[i] = 1'b1;
			end else if ((own && new_connect) || clr[i]) begin
				state_next.cmp[i] = 1'b0;
			end
			// no reply within the window counts as a reject
			if (func_sent) begin
				state_next.tmo_run[i] = 1'b1;
				state_next.tmo_cnt[i] = 12'h000;
				state_next.tmo_rej[i] = 1'b0;
			end else if (ctrl_reply[i] || clr[i]) begin
				state_next.tmo_run[i] = 1'b0;
				if (clr[i]) begin
					state_next.tmo_rej[i] = 1'b0;
				end
			end else if (state_reg.tmo_run[i]) begin
				if (state_reg.tmo_cnt[i] == 12'(REJECT_CYCLES - 1)) begin
					state_next.tmo_run[i] = 1'b0;
					state_next.tmo_rej[i] = 1'b1;
				end else begin
					state_next.tmo_cnt[i] = state_reg.tmo_cnt[i] + 12'h001;
				end
			end
		end

		// status channel a, presented for the connected channel
		if (connected) begin
			if (state_reg.cur_sel[ch]) begin
				wa[chan_status_pkg::STA_ADDR_LSB +: 11] =
					cur_word_addr[ch];
			end else begin
				wa[chan_status_pkg::STA_BCNT_LSB +: 4] =
					last_byte_count[ch];
			end
		end

		// status channel b: controller word or scanner word
		if (connected) begin
			wb[chan_status_pkg::STB_PARITY] = ctrl_parity_err[ch];
			wb[chan_status_pkg::STB_EOR] = ctrl_eor[ch];
			wb[chan_status_pkg::STB_REJECT] =
				ctrl_refuse[ch] || state_reg.tmo_rej[ch];
			wb[chan_status_pkg::STB_REPLY] = ctrl_reply[ch];
			for (int k = 0; k < 12; k++) begin
				wb[chan_status_pkg::STB_CSTAT_LSB + k] =
					ctrl_status[ch][11 - k];
			end
		end else if (code == chan_status_pkg::CODE_SCANNER) begin
			wb[chan_status_pkg::SCN_SLOT_FREE0] = state_reg.slot_free[0];
			wb[chan_status_pkg::SCN_SLOT_FREE1] = state_reg.slot_free[1];
			wb[chan_status_pkg::SCN_RESP0] = state_reg.resp[0];
			wb[chan_status_pkg::SCN_RESP1] = state_reg.resp[1];
			wb[chan_status_pkg::SCN_CMP0] = state_reg.cmp[0];
			wb[chan_status_pkg::SCN_CMP1] = state_reg.cmp[1];
		end

		// one registered copy so every read sees a coherent word
		state_next.stat_a = wa;
		state_next.stat_b = wb;
	end

	// ************************************************
	// state register
	// ************************************************
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign link.status_input_channel_a = state_reg.stat_a;
	assign link.status_input_channel_b = state_reg.stat_b;
	assign cmd_valid = state_reg.cmd_valid;
	assign cmd_chan = state_reg.cmd_chan;
	assign cmd_kind = state_reg.cmd_kind;
	assign cmd_data = state_reg.cmd_data;
endmodule : chan_status_dev

// ===== verilog/chan_status_host.sv
`timescale 1ns/1ns
module chan_status_host (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link to the channel interface
	chan_link_if.host link
);
	typedef struct packed {
		logic [15:0] ctl;
		logic [15:0] data;
		logic [15:0] stat_a;
		logic [15:0] stat_b;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} host_state_t;

	host_state_t state_reg;
	host_state_t state_next;

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == chan_status_pkg::OFF_CTL) ||
			(a == chan_status_pkg::OFF_DATA) ||
			(a == chan_status_pkg::OFF_STAT_A) ||
			(a == chan_status_pkg::OFF_STAT_B);
	endfunction : is_mapped

	// ************************************************
	// register access
	// ************************************************
	always_comb begin
		logic setup;
		setup = psel && !penable;
		state_next = state_reg;
		// status is sampled every cycle; software orders the
		// connect, scanner code and bit 6 before reading
		state_next.stat_a = link.status_input_channel_a;
		state_next.stat_b = link.status_input_channel_b;
		state_next.pready = 1'b0;
		state_next.pslverr = 1'b0;
		// answer one cycle after setup: ready on the first access edge
		if (setup) begin
			state_next.pready = 1'b1;
			state_next.pslverr = !is_mapped(paddr);
			state_next.prdata = 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					chan_status_pkg::OFF_CTL:
						state_next.prdata = {16'h0000, state_reg.ctl};
					chan_status_pkg::OFF_DATA:
						state_next.prdata = {16'h0000, state_reg.data};
					chan_status_pkg::OFF_STAT_A:
						state_next.prdata = {16'h0000, state_reg.stat_a};
					chan_status_pkg::OFF_STAT_B:
						state_next.prdata = {16'h0000, state_reg.stat_b};
					default:
						state_next.prdata = 32'h0000_0000;
				endcase
			end
		end
		// writes land at the completing edge only
		if (psel && penable && state_reg.pready && pwrite) begin
			if (paddr == chan_status_pkg::OFF_CTL) begin
				// code stays on the channel until software changes it
				state_next.ctl = pwdata[15:0];
			end else if (paddr == chan_status_pkg::OFF_DATA) begin
				state_next.data = pwdata[15:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign link.control_output_channel_b = state_reg.ctl;
	assign link.control_output_channel_a = state_reg.data;
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
endmodule : chan_status_host

// ===== verilog/chan_status_pkg.sv
// Functional notes
// - connect code selects default status word
// - control bit 6 selects current address word
// - channel b carries status and four signals
// - bit 0 reports controller parity error
// - bit 1 reports end of record
// - bit 2 reject, refused or 100 us timeout
// - bit 3 reports controller reply
// - bits 4..F carry status 11 down to 0
// - host issues scanner code before reading b
// - scanner bits 6/8 flag response per channel
// - scanner bits 0/1 flag next page slot free
// - slot free flag clears on page load
// - scanner bits 7/9 flag write address compare
// - current address word bits 5..15 address
// - default word bits 9..12 byte count
// - table address strobe returns to default status
// - host reloads next page on slot free
// - host checks channels a and b on response
// - host connects before reading controller status
// - host keeps bit 6 clear for default
// - codes C/D connect, only while present
// - current address stays until selection cleared
package chan_status_pkg;
	// ************************************************
	// control word layout
	// ************************************************
	localparam int CTL_START_ADDR = 0;
	localparam int CTL_TERM_ADDR = 1;
	localparam int CTL_INT_FUNC = 2;
	localparam int CTL_PROG_CLEAR = 3;
	localparam int CTL_CHAN_FUNC = 4;
	localparam int CTL_TABLE_ADDR = 5;
	localparam int CTL_CUR_ADDR = 6;
	localparam int CTL_CODE_LSB = 12;
	localparam logic [3:0] CODE_CH0 = 4'hC;
	localparam logic [3:0] CODE_CH1 = 4'hD;
	localparam logic [3:0] CODE_SCANNER = 4'h6;
	// ************************************************
	// status word layouts
	// ************************************************
	localparam int STB_PARITY = 0;
	localparam int STB_EOR = 1;
	localparam int STB_REJECT = 2;
	localparam int STB_REPLY = 3;
	localparam int STB_CSTAT_LSB = 4;
	localparam int SCN_SLOT_FREE0 = 0;
	localparam int SCN_SLOT_FREE1 = 1;
	localparam int SCN_RESP0 = 6;
	localparam int SCN_CMP0 = 7;
	localparam int SCN_RESP1 = 8;
	localparam int SCN_CMP1 = 9;
	localparam int STA_ADDR_LSB = 5;
	localparam int STA_BCNT_LSB = 9;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_MHZ = 25;
	localparam int REJECT_TIME_US = 100;
	localparam int REJECT_CYCLES = REJECT_TIME_US * CLK_MHZ;
	// ************************************************
	// host register map
	// ************************************************
	localparam logic [11:0] OFF_CTL = 12'h000;
	localparam logic [11:0] OFF_DATA = 12'h004;
	localparam logic [11:0] OFF_STAT_A = 12'h008;
	localparam logic [11:0] OFF_STAT_B = 12'h00C;
endpackage : chan_status_pkg
